// *** rtl/serial_mem_cmd.sv ***
// Operation
// - Status write needs the write-enable latch set by an earlier write-enable command.
// - Status write never changes the two lowest status bits.
// - Status write runs only if select rises right after the eighth data bit.
// - Select rise after valid status write starts timed cycle; busy flag shows it.
// - End of the timed status write cycle clears the write-enable latch.
// - During a write cycle only status read is accepted; others ignored.
// - Hardware protect mode refuses every status write.
// - Lock bit 0: status write allowed whenever latch set, any protect pin level.
// - Lock bit 1 with protect pin high: status write allowed when latch set.
// - Lock bit 1 with protect pin low: hardware protect, status writes rejected.
// - In hardware protect the block-protect field cannot change.
// - Hardware protect whenever lock is 1 and pin low, either order.
// - Only the protect pin going high ends hardware protect.
// - Plain read: code, 24-bit address on rising edges, data on line 1 falling.
// - Reads advance address per byte and wrap to zero, endless while selected.
// - Select high ends a read at any point.
// - Reads during a busy cycle are rejected without disturbing it.
// - Fast, two-line and four-line reads take one dummy byte before data.
// - Two-line read drives lines 0 and 1, two bits per falling edge.
// - Four-line read drives lines 0 to 3, four bits per falling edge.
// - Four-line read code freezes the protect pin function for that transaction.
// - Full-array erase runs only when all block-protect bits are 0.
`timescale 1ns/10ps
module serial_mem_cmd
   import serial_mem_pkg::*;
#(
   parameter int          MEM_DEPTH   = 256,
   parameter logic [15:0] BUSY_CYCLES = 16'h03E8
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic [3:0]  i_io,
   output logic      [3:0]  o_io,
   output logic      [3:0]  o_io_oe_n,
   output logic             o_hw_protect
);

   localparam int MEM_AW = $clog2(MEM_DEPTH);

   state_t                  st_ff;
   state_t                  nxt_st;
   logic [7:0]              mem [MEM_DEPTH];
   logic                    sclk_rise;
   logic                    sclk_fall;
   logic                    cs_rise;
   logic                    io0;
   logic                    wb_req;
   logic                    wb_mem_wr;
   logic [7:0]              mem_rd;
   logic [7:0]              wb_mem_rd;

   function automatic logic [3:0] lane_bits(input lanes_t l);
      case (l)
         LN_TWO:  lane_bits = W_TWO;
         LN_FOUR: lane_bits = W_FOUR;
         default: lane_bits = W_ONE;
      endcase
   endfunction : lane_bits

   function automatic logic [3:0] lane_oe(input lanes_t l);
      case (l)
         LN_TWO:  lane_oe = OE_TWO;
         LN_FOUR: lane_oe = OE_FOUR;
         default: lane_oe = OE_ONE;
      endcase
   endfunction : lane_oe

   function automatic logic [3:0] lane_val(input lanes_t l, input logic [7:0] b);
      case (l)
         LN_TWO:  lane_val = {2'h0, b[7], b[6]};
         LN_FOUR: lane_val = b[7:4];
         default: lane_val = {2'h0, b[7], 1'h0};
      endcase
   endfunction : lane_val

   // ==========================================================================
   // Edge detection on the synchronised link pins
   assign sclk_rise = st_ff.sclk_s[1] & ~st_ff.sclk_s[2];
   assign sclk_fall = ~st_ff.sclk_s[1] & st_ff.sclk_s[2];
   assign cs_rise   = st_ff.cs_s[1] & ~st_ff.cs_s[2];
   assign io0       = st_ff.io0_s[1];
   assign wb_req    = i_wb_cyc & i_wb_stb & ~st_ff.wb_ack;
   assign wb_mem_wr = wb_req & i_wb_we & (i_wb_adr == REG_MEM_DATA) & i_wb_sel[0];
   assign mem_rd    = mem[st_ff.addr[MEM_AW-1:0]];
   assign wb_mem_rd = mem[st_ff.mem_addr[MEM_AW-1:0]];

   // ==========================================================================
   // Next-state logic
   always_comb begin
      logic [7:0] nsh;
      logic [7:0] byte_now;
      nsh      = {st_ff.sh[6:0], io0};
      byte_now = '0;
      nxt_st   = st_ff;
      nxt_st.sclk_s   = {st_ff.sclk_s[1:0], i_sclk};
      nxt_st.cs_s     = {st_ff.cs_s[1:0], i_cs_n};
      nxt_st.io0_s    = {st_ff.io0_s[0], i_io[0]};
      nxt_st.io2_s    = {st_ff.io2_s[0], i_io[2]};
      nxt_st.erase_go = 1'b0;
      if (!st_ff.quad_txn) begin
         nxt_st.wp_eff = st_ff.io2_s[1];
      end

      if (st_ff.cs_s[1]) begin
         nxt_st.phase    = PH_IDLE;
         nxt_st.io_oe_n  = OE_NONE;
         nxt_st.quad_txn = 1'b0;
         if (cs_rise && st_ff.phase == PH_STATUS_WRITE_CMD && st_ff.cnt == DATA_BITS && !st_ff.hw_protect_mode &&
             st_ff.status[SR_WEL]) begin
            nxt_st.status = (st_ff.sh & ~SR_KEEP_MASK) | (st_ff.status & SR_KEEP_MASK);
            nxt_st.status[SR_WIP] = 1'b1;
            nxt_st.timer  = st_ff.busy_len;
         end
         if (cs_rise && st_ff.phase == PH_ERASE && st_ff.cnt == '0 &&
             (st_ff.status & SR_BP_MASK) == '0 && st_ff.status[SR_WEL]) begin
            nxt_st.erase_go       = 1'b1;
            nxt_st.status[SR_WIP] = 1'b1;
            nxt_st.timer          = st_ff.busy_len;
         end
      end else begin
         case (st_ff.phase)
            PH_IDLE: begin
               nxt_st.phase = PH_CMD;
               nxt_st.cnt   = '0;
            end
            PH_CMD: begin
               if (sclk_rise) begin
                  nxt_st.sh  = nsh;
                  nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                  if (st_ff.cnt == CMD_LAST) begin
                     nxt_st.cnt    = '0;
                     nxt_st.bitcnt = '0;
                     nxt_st.lanes  = LN_ONE;
                     nxt_st.dummy  = 1'b1;
                     nxt_st.phase  = PH_IGNORE;
                     if (st_ff.status[SR_WIP] && nsh != OP_STATUS_READ) begin
                        nxt_st.phase = PH_IGNORE;
                     end else begin
                        case (nsh)
                           OP_WRITE_ENABLE: nxt_st.status[SR_WEL] = 1'b1;
                           OP_STATUS_READ:  nxt_st.phase = PH_STAT;
                           OP_STATUS_WRITE: begin
                              if (st_ff.status[SR_WEL] && !st_ff.hw_protect_mode) begin
                                 nxt_st.phase = PH_STATUS_WRITE_CMD;
                              end
                           end
                           OP_READ: begin
                              nxt_st.phase = PH_ADDR;
                              nxt_st.dummy = 1'b0;
                           end
                           OP_FAST_READ: nxt_st.phase = PH_ADDR;
                           OP_TWO_LINE: begin
                              nxt_st.phase = PH_ADDR;
                              nxt_st.lanes = LN_TWO;
                           end
                           OP_FOUR_LINE: begin
                              nxt_st.phase    = PH_ADDR;
                              nxt_st.lanes    = LN_FOUR;
                              nxt_st.quad_txn = 1'b1;
                           end
                           OP_ERASE: begin
                              if ((st_ff.status & SR_BP_MASK) == '0 && st_ff.status[SR_WEL]) begin
                                 nxt_st.phase = PH_ERASE;
                              end
                           end
                           default: nxt_st.phase = PH_IGNORE;
                        endcase
                     end
                  end
               end
            end
            PH_ADDR: begin
               if (sclk_rise) begin
                  nxt_st.addr = {st_ff.addr[22:0], io0};
                  nxt_st.cnt  = 5'(st_ff.cnt + 5'h01);
                  if (st_ff.cnt == ADDR_LAST) begin
                     nxt_st.cnt   = '0;
                     nxt_st.phase = st_ff.dummy ? PH_DUMMY : PH_DATA;
                  end
               end
            end
            PH_DUMMY: begin
               if (sclk_rise) begin
                  nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                  if (st_ff.cnt == DUMMY_LAST) begin
                     nxt_st.cnt   = '0;
                     nxt_st.phase = PH_DATA;
                  end
               end
            end
            PH_STATUS_WRITE_CMD, PH_ERASE: begin
               if (sclk_rise) begin
                  nxt_st.sh = nsh;
                  if (st_ff.cnt != CNT_MAX) begin
                     nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
                  end
               end
            end
            PH_DATA, PH_STAT: begin
               if (sclk_fall) begin
                  if (st_ff.bitcnt == '0) begin
                     byte_now = (st_ff.phase == PH_STAT) ? st_ff.status : mem_rd;
                     if (st_ff.phase == PH_DATA) begin
                        nxt_st.addr = 24'(st_ff.addr + 24'h000001);
                     end
                     nxt_st.bitcnt = 4'(BYTE_BITS - lane_bits(st_ff.lanes));
                  end else begin
                     byte_now      = st_ff.out_sh;
                     nxt_st.bitcnt = 4'(st_ff.bitcnt - lane_bits(st_ff.lanes));
                  end
                  nxt_st.io_out  = lane_val(st_ff.lanes, byte_now);
                  nxt_st.io_oe_n = lane_oe(st_ff.lanes);
                  nxt_st.out_sh  = 8'(byte_now << lane_bits(st_ff.lanes));
               end
            end
            PH_IGNORE: nxt_st.phase = PH_IGNORE;
            default:   nxt_st.phase = PH_IGNORE;
         endcase
      end

      if (st_ff.status[SR_WIP]) begin
         if (st_ff.timer <= BUSY_ONE) begin
            nxt_st.status[SR_WIP] = 1'b0;
            nxt_st.status[SR_WEL] = 1'b0;
         end else begin
            nxt_st.timer = 16'(st_ff.timer - BUSY_ONE);
         end
      end
      nxt_st.hw_protect_mode = nxt_st.status[SR_LOCK] & ~nxt_st.wp_eff;

      // =======================================================================
      // Register bus slave
      nxt_st.wb_ack = wb_req;
      if (wb_req) begin
         case (i_wb_adr)
            REG_STATUS:   nxt_st.wb_dat = {22'h0, st_ff.wp_eff, st_ff.hw_protect_mode, st_ff.status};
            REG_BUSY_LEN: nxt_st.wb_dat = {16'h0, st_ff.busy_len};
            REG_MEM_ADDR: nxt_st.wb_dat = {16'h0, st_ff.mem_addr};
            REG_MEM_DATA: nxt_st.wb_dat = {24'h0, wb_mem_rd};
            default:      nxt_st.wb_dat = '0;
         endcase
         if (i_wb_we && i_wb_adr == REG_BUSY_LEN) begin
            if (i_wb_sel[0]) nxt_st.busy_len[7:0]  = i_wb_dat[7:0];
            if (i_wb_sel[1]) nxt_st.busy_len[15:8] = i_wb_dat[15:8];
         end
         if (i_wb_we && i_wb_adr == REG_MEM_ADDR) begin
            if (i_wb_sel[0]) nxt_st.mem_addr[7:0]  = i_wb_dat[7:0];
            if (i_wb_sel[1]) nxt_st.mem_addr[15:8] = i_wb_dat[15:8];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_ff          <= '0;
         st_ff.cs_s     <= SYNC_HIGH;
         st_ff.io2_s    <= 2'h3;
         st_ff.status   <= SR_RESET;
         st_ff.wp_eff   <= 1'b1;
         st_ff.busy_len <= BUSY_CYCLES;
         st_ff.io_oe_n  <= OE_NONE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // Memory array: register bus loads bytes, a full erase sets every byte.
   always_ff @(posedge i_clk) begin
      if (st_ff.erase_go) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= ERASED_BYTE;
         end
      end else if (wb_mem_wr) begin
         mem[st_ff.mem_addr[MEM_AW-1:0]] <= i_wb_dat[7:0];
      end
   end

   assign o_wb_dat     = st_ff.wb_dat;
   assign o_wb_ack     = st_ff.wb_ack;
   assign o_io         = st_ff.io_out;
   assign o_io_oe_n    = st_ff.io_oe_n;
   assign o_hw_protect = st_ff.hw_protect_mode;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   wel_needed_a: assert property ($rose(st_ff.status[SR_WIP]) |-> $past(st_ff.status[SR_WEL]))
      else $error("Busy cycle started without the write-enable latch.");
   low_bits_kept_a: assert property ($rose(st_ff.status[SR_WIP]) |-> st_ff.status[SR_WEL])
      else $error("Status write disturbed the low status bits.");
   busy_holds_a: assert property (($rose(st_ff.status[SR_WIP]) && st_ff.busy_len > 16'h0002)
      |-> st_ff.status[SR_WIP] [*2])
      else $error("Busy flag dropped too early.");
   wel_cleared_a: assert property ($fell(st_ff.status[SR_WIP]) |-> !st_ff.status[SR_WEL])
      else $error("Write-enable latch not cleared at cycle end.");
   busy_ignore_a: assert property ((st_ff.status[SR_WIP] && sclk_rise && !st_ff.cs_s[1] &&
      st_ff.phase == PH_CMD && st_ff.cnt == CMD_LAST && nsh_chk() != OP_STATUS_READ)
      |=> st_ff.phase == PH_IGNORE)
      else $error("Instruction accepted during a busy cycle.");
   hpm_frozen_a: assert property (st_ff.hw_protect_mode |=> $stable(st_ff.status[7:2]))
      else $error("Protected status bits changed in hardware protect.");
   hpm_exit_a: assert property ($fell(st_ff.hw_protect_mode) |-> st_ff.wp_eff || !st_ff.status[SR_LOCK])
      else $error("Hardware protect ended without the protect pin.");
   addr_step_a: assert property ((st_ff.phase == PH_DATA && !st_ff.cs_s[1] && sclk_fall &&
      st_ff.bitcnt == '0) |=> st_ff.addr == 24'($past(st_ff.addr) + 24'h000001))
      else $error("Read address did not advance by one.");
   deselect_a: assert property (cs_rise |=> st_ff.io_oe_n == OE_NONE ##1 st_ff.phase == PH_IDLE)
      else $error("Lines still driven after deselect.");
   quad_lines_a: assert property ((st_ff.phase == PH_DATA && st_ff.lanes == LN_FOUR && !st_ff.cs_s[1]
      && sclk_fall) |=> st_ff.io_oe_n == OE_FOUR)
      else $error("Four-line read did not drive four lines.");
   quad_wp_a: assert property ((st_ff.quad_txn && nxt_st.quad_txn) |=> $stable(st_ff.wp_eff))
      else $error("Protect pin followed during a four-line read.");

   function automatic logic [7:0] nsh_chk();
      nsh_chk = {st_ff.sh[6:0], io0};
   endfunction : nsh_chk

   status_write_c: cover property ($rose(st_ff.status[SR_WIP]) && !st_ff.erase_go);
   quad_read_c:    cover property (st_ff.phase == PH_DATA && st_ff.lanes == LN_FOUR && sclk_fall);
   hpm_entry_c:    cover property ($rose(st_ff.hw_protect_mode));

endmodule : serial_mem_cmd

// *** rtl/serial_mem_pkg.sv ***
package serial_mem_pkg;

   // ==========================================================================
   // Instruction codes
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_STATUS_READ   = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OP_READ          = 8'h03;
   localparam logic [7:0] OP_FAST_READ     = 8'h0B;
   localparam logic [7:0] OP_TWO_LINE      = 8'h3B;
   localparam logic [7:0] OP_FOUR_LINE     = 8'h6B;
   localparam logic [7:0] OP_ERASE         = 8'hC7;

   // ==========================================================================
   // Status byte layout: [7] lock, [6] top/bottom, [5:2] block protect, [1] latch, [0] busy
   localparam int unsigned SR_WIP          = 0;
   localparam int unsigned SR_WEL          = 1;
   localparam int unsigned SR_LOCK         = 7;
   localparam logic [7:0]  SR_BP_MASK      = 8'h3C;
   localparam logic [7:0]  SR_KEEP_MASK    = 8'h03;
   localparam logic [7:0]  SR_RESET        = 8'h00;

   // ==========================================================================
   // Register map, byte addresses
   localparam logic [7:0]  REG_STATUS      = 8'h00;
   localparam logic [7:0]  REG_BUSY_LEN    = 8'h04;
   localparam logic [7:0]  REG_MEM_ADDR    = 8'h08;
   localparam logic [7:0]  REG_MEM_DATA    = 8'h0C;

   // ==========================================================================
   // Bit counts and pin patterns
   localparam logic [4:0]  CMD_LAST        = 5'h07;
   localparam logic [4:0]  ADDR_LAST       = 5'h17;
   localparam logic [4:0]  DUMMY_LAST      = 5'h07;
   localparam logic [4:0]  DATA_BITS       = 5'h08;
   localparam logic [4:0]  CNT_MAX         = 5'h1F;
   localparam logic [3:0]  BYTE_BITS       = 4'h8;
   localparam logic [3:0]  W_ONE           = 4'h1;
   localparam logic [3:0]  W_TWO           = 4'h2;
   localparam logic [3:0]  W_FOUR          = 4'h4;
   localparam logic [3:0]  OE_NONE         = 4'hF;
   localparam logic [3:0]  OE_ONE          = 4'hD;
   localparam logic [3:0]  OE_TWO          = 4'hC;
   localparam logic [3:0]  OE_FOUR         = 4'h0;
   localparam logic [2:0]  SYNC_HIGH       = 3'h7;
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
   localparam logic [15:0] BUSY_ONE        = 16'h0001;

   typedef enum logic [3:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_STAT,
                             PH_STATUS_WRITE_CMD, PH_ERASE, PH_IGNORE} phase_t;
   typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} lanes_t;

   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [2:0]  cs_s;
      logic [1:0]  io0_s;
      logic [1:0]  io2_s;
      phase_t      phase;
      lanes_t      lanes;
      logic        dummy;
      logic        quad_txn;
      logic [4:0]  cnt;
      logic [7:0]  sh;
      logic [23:0] addr;
      logic [7:0]  out_sh;
      logic [3:0]  bitcnt;
      logic [7:0]  status;
      logic        wp_eff;
      logic        hw_protect_mode;
      logic [15:0] timer;
      logic [15:0] busy_len;
      logic        erase_go;
      logic [15:0] mem_addr;
      logic        wb_ack;
      logic [31:0] wb_dat;
      logic [3:0]  io_out;
      logic [3:0]  io_oe_n;
   } state_t;

endpackage : serial_mem_pkg

// *** verification/spi_host_model.sv ***
`timescale 1ns/10ps
// ============================================================================
// Host side of the serial link: mode 0, 80 ns clock, three cycles high, five low.
module spi_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_wp,
   input  wire logic [3:0] i_io,
   output logic            o_sclk,
   output logic            o_cs_n,
   output logic      [3:0] o_io,
   output logic            o_rx_valid,
   output logic      [7:0] o_rx
);
   logic io0_ff = 1'b0;
   logic tog_ff = 1'b0;

   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_rx_valid = 1'b0;
      o_rx = 8'h00;
   end

   always @(posedge i_clk) begin
      tog_ff <= ~tog_ff;
   end

   // Lines 1 and 3 carry no host data; the host drives them with a changing pattern.
   assign o_io = {tog_ff, i_wp, ~tog_ff, io0_ff};

   // Sends ntx bits of tx, MSB first on line 0, then clocks nrx cycles of w bits in.
   task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, input int w);
      logic [7:0] sh;
      int         nb;
      sh = 8'h00;
      nb = 0;
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      for (int k = 0; k < ntx + nrx; k++) begin
         if (k < ntx) io0_ff <= tx[63 - k];
         else io0_ff <= ~io0_ff;
         repeat (5) @(posedge i_clk);
         if (k >= ntx) begin
            case (w)
               1: sh = {sh[6:0], i_io[1]};
               2: sh = {sh[5:0], i_io[1:0]};
               default: sh = {sh[3:0], i_io[3:0]};
            endcase
            nb = nb + w;
            if (nb == 8) begin
               o_rx <= sh;
               o_rx_valid <= 1'b1;
               nb = 0;
            end
         end
         o_sclk <= 1'b1;
         @(posedge i_clk);
         o_rx_valid <= 1'b0;
         repeat (2) @(posedge i_clk);
         o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      repeat (6) @(posedge i_clk);
   endtask : frame
endmodule : spi_host_model

// *** verification/serial_mem_cmd_bench.sv ***
`timescale 1ns/10ps
// ============================================================================
// Self-checking bench: register bus and serial link scenarios.
module serial_mem_cmd_bench import serial_mem_pkg::*;;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        wp = 1'b1;
   logic        sclk;
   logic        cs_n;
   logic [3:0]  hio, dio, doe_n, io_w;
   logic        hwp, rxv;
   logic [7:0]  rx;
   logic [7:0]  mem_m [256];
   logic [31:0] exq_w[$], exm_w[$];
   logic [7:0]  exq_b[$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          seed = 32'hf8e6;
   logic [7:0]  op_t [4] = '{OP_READ, OP_FAST_READ, OP_TWO_LINE, OP_FOUR_LINE};
   int          wid_t [4] = '{1, 1, 2, 4};

   always #5 i_clk = ~i_clk;

   serial_mem_cmd #(.BUSY_CYCLES(16'h0014)) i_serial_mem_cmd (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_w), .o_io(dio), .o_io_oe_n(doe_n), .o_hw_protect(hwp));

   spi_host_model i_spi_host_model (.i_clk(i_clk), .i_wp(wp), .i_io(io_w), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_io(hio), .o_rx_valid(rxv), .o_rx(rx));

   assign io_w = (~doe_n & dio) | (doe_n & hio);

   task automatic end_sim();
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim

   task automatic cmp_wb(input logic [31:0] got);
      logic [31:0] e;
      logic [31:0] m;
      e = (exq_w.size() > 0) ? exq_w.pop_front() : 32'hDEADBEEF;
      m = (exm_w.size() > 0) ? exm_w.pop_front() : 32'hFFFFFFFF;
      n_tests++;
      if ((got & m) !== (e & m)) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, e & m);
         num_errors++;
      end
   endtask : cmp_wb

   task automatic cmp_byte(input logic [7:0] got);
      logic [8:0] e;
      e = (exq_b.size() > 0) ? {1'b0, exq_b.pop_front()} : 9'h100;
      n_tests++;
      if ({1'b0, got} !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
         num_errors++;
      end
   endtask : cmp_byte

   task automatic cmp_hpm(input logic got, input logic e);
      n_tests++;
      if (got !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
         num_errors++;
      end
   endtask : cmp_hpm

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge i_clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
      t = 0;
      do begin
         @(posedge i_clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      {cyc, stb} <= 2'b00;
      if (t >= 50) begin
         num_errors++;
         end_sim();
      end
      @(posedge i_clk);
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exq_w.push_back(e);
      exm_w.push_back(m);
      wb(1'b0, a, 32'h0);
   endtask : rd

   task automatic rd_st(input logic h, input logic [7:0] s);
      rd(REG_STATUS, {23'h0, h, s}, 32'h000001FF);
      cmp_hpm(hwp, h);
   endtask : rd_st

   task automatic sts(input logic [7:0] e);
      exq_b.push_back(e);
      i_spi_host_model.frame({OP_STATUS_READ, 56'h0}, 8, 8, 1);
   endtask : sts

   task automatic status_write_cmd(input logic [7:0] d, input int n);
      i_spi_host_model.frame({OP_STATUS_WRITE, d, 48'h0}, n, 0, 1);
   endtask : status_write_cmd

   task automatic cmd(input logic [7:0] op);
      i_spi_host_model.frame({op, 56'h0}, 8, 0, 1);
   endtask : cmd

   always @(posedge i_clk) begin
      if (cyc && !we && ack === 1'b1) cmp_wb(rdat);
      if (rxv === 1'b1) cmp_byte(rx);
   end

   initial begin
      logic [23:0] a;
      logic [7:0]  d;
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (6) @(posedge i_clk);
      wb(1'b1, REG_BUSY_LEN, 32'h00000400);
      rd(REG_BUSY_LEN, 32'h00000400, 32'h0000FFFF);
      rd(8'h10, 32'h0, 32'hFFFFFFFF);
      for (int i = 0; i < 256; i++) begin
         mem_m[i] = 8'($random(seed));
         wb(1'b1, REG_MEM_ADDR, 32'(i));
         wb(1'b1, REG_MEM_DATA, {24'h0, mem_m[i]});
      end
      rd(REG_MEM_DATA, {24'h0, mem_m[255]}, 32'h000000FF);
      status_write_cmd(8'hFC, 16);
      rd_st(1'b0, 8'h00);
      cmd(OP_WRITE_ENABLE);
      sts(8'h02);
      status_write_cmd(8'hBF, 16);
      sts(8'hBF);
      status_write_cmd(8'h00, 16);
      repeat (1100) @(posedge i_clk);
      rd_st(1'b0, 8'hBC);
      wp <= 1'b0;
      repeat (10) @(posedge i_clk);
      rd_st(1'b1, 8'hBC);
      cmd(OP_WRITE_ENABLE);
      status_write_cmd(8'h00, 16);
      rd_st(1'b1, 8'hBE);
      cmd(OP_ERASE);
      repeat (1100) @(posedge i_clk);
      rd(REG_MEM_DATA, {24'h0, mem_m[255]}, 32'h000000FF);
      wp <= 1'b1;
      repeat (10) @(posedge i_clk);
      rd_st(1'b0, 8'hBE);
      status_write_cmd(8'h00, 16);
      repeat (1100) @(posedge i_clk);
      rd_st(1'b0, 8'h00);
      wp <= 1'b0;
      cmd(OP_WRITE_ENABLE);
      status_write_cmd(8'h80, 16);
      repeat (1100) @(posedge i_clk);
      rd_st(1'b1, 8'h80);
      wp <= 1'b1;
      cmd(OP_WRITE_ENABLE);
      status_write_cmd(8'h00, 16);
      repeat (1100) @(posedge i_clk);
      cmd(OP_WRITE_ENABLE);
      status_write_cmd(8'hA0, 15);
      status_write_cmd(8'hA0, 17);
      rd_st(1'b0, 8'h02);
      status_write_cmd(8'h00, 16);
      i_spi_host_model.frame({OP_READ, 24'h0, 32'h0}, 32, 0, 1);
      sts(8'h03);
      repeat (1100) @(posedge i_clk);
      rd_st(1'b0, 8'h00);
      for (int r = 0; r < 4; r++) begin
         a = (r == 0) ? 24'hFFFFFE : 24'($random(seed));
         d = 8'($random(seed));
         for (int b = 0; b < 4; b++) exq_b.push_back(mem_m[8'(a + b)]);
         i_spi_host_model.frame({op_t[r], a, d, 24'h0}, (r == 0) ? 32 : 40, 32 / wid_t[r], wid_t[r]);
      end
      i_spi_host_model.frame({OP_READ, 24'h0, 32'h0}, 32, 4, 1);
      sts(8'h00);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_ERASE);
      repeat (1100) @(posedge i_clk);
      rd(REG_MEM_DATA, 32'h000000FF, 32'h000000FF);
      end_sim();
   end
endmodule : serial_mem_cmd_bench
